// ---- src/rlei_pkg.sv ----
// shared constants and types of the receive link error interrupt block
package rlei_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_SYSREF_ALWAYSON = 8'h54;
  localparam logic [7:0] OFS_EMB_LENGTH = 8'h58;
  localparam logic [7:0] OFS_ERR_STATUS = 8'h60;
  localparam logic [7:0] OFS_ERR_ENABLE = 8'h64;

  // status and enable bit positions, same layout in both registers
  localparam int BIT_SYSREF_LEMC = 0;
  localparam int BIT_LINK_READY = 1;
  localparam int BIT_FRAME_READY = 2;
  localparam int BIT_CMD_READY = 3;
  localparam int BIT_CDR_LOCK = 4;
  localparam int BIT_PCFIFO_FULL = 5;
  localparam int BIT_PCFIFO_EMPTY = 6;
  localparam int BIT_LANE_DESKEW = 7;
  localparam int BIT_INV_SYNC_HDR = 8;
  localparam int BIT_INV_EOMB = 9;
  localparam int BIT_INV_EOEMB = 10;
  localparam int BIT_CMD_PARITY = 11;
  localparam int BIT_CRC = 14;
  localparam int BIT_GEARBOX_UNDER = 16;
  localparam int BIT_GEARBOX_OVER = 17;
  localparam int BIT_HEADER_UNLOCK = 18;
  localparam int BIT_EMB_UNLOCK = 19;
  localparam int BIT_ELASTIC_OVER = 20;
  localparam int BIT_ECC_CORRECTED = 21;
  localparam int BIT_ECC_FATAL = 22;

  // implemented bits; 31:23, 15, 13 and 12 are reserved and read zero
  localparam logic [31:0] ERR_IMPL_MASK = 32'h007f_4fff;
  localparam logic [31:0] ERR_ENABLE_RESET = 32'h005f_4ff1;
  localparam logic [31:0] ERR_STATUS_RESET = 32'h0000_0000;
  localparam logic SYSREF_ALWAYSON_RESET = 1'h0;

  // extended multiblock length E and the blocks per multiblock
  localparam int EMB_LEN_W = 5;
  localparam logic [EMB_LEN_W-1:0] EMB_LENGTH_RESET = 5'h01;
  localparam int BLOCKS_PER_MB = 32;

  // one streaming handshake as seen by the monitor
  typedef struct packed {
    logic valid;
    logic ready;
  } rlei_stream_t;

  // detected link faults arriving as one-cycle pulses
  typedef struct packed {
    logic ecc_fatal;
    logic ecc_corrected;
    logic elastic_over;
    logic emb_unlock;
    logic header_unlock;
    logic gearbox_over;
    logic gearbox_under;
    logic crc;
    logic cmd_parity;
    logic inv_eoemb;
    logic inv_eomb;
    logic inv_sync_hdr;
    logic lane_deskew;
    logic pcfifo_empty;
    logic pcfifo_full;
    logic cdr_lock;
  } rlei_fault_t;

endpackage : rlei_pkg

// ---- src/rlei_ready_mon.sv ----
// sink-not-ready detector for one streaming output
module rlei_ready_mon (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire rlei_pkg::rlei_stream_t i_stream,
  output logic o_err
);

  logic err_r;

  // registered so the status update sees a clean pulse, high one cycle after each stalled cycle
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      err_r <= 1'b0;
    end else begin
      err_r <= i_stream.valid & ~i_stream.ready;
    end
  end

  assign o_err = err_r;

endmodule : rlei_ready_mon

// ---- src/rlei_sysref_check.sv ----
// reference pulse against extended multiblock period checker
module rlei_sysref_check #(
  parameter int EMB_LEN_W = rlei_pkg::EMB_LEN_W
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_enable,
  input wire logic [EMB_LEN_W-1:0] i_emb_length,
  input wire logic i_sysref_sync,
  output logic o_mismatch
);

  localparam int CNT_W = EMB_LEN_W + $clog2(rlei_pkg::BLOCKS_PER_MB);

  logic sysref_d_r;
  logic aligned_r;
  logic mismatch_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] period;
  logic sysref_rise;

  assign period = CNT_W'({i_emb_length, 5'h00});
  assign sysref_rise = i_sysref_sync & ~sysref_d_r;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sysref_d_r <= 1'b0;
    end else begin
      sysref_d_r <= i_sysref_sync;
    end
  end

  // the first pulse after enabling only aligns the counter
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_r <= '0;
      aligned_r <= 1'b0;
    end else if (!i_enable) begin
      cnt_r <= '0;
      aligned_r <= 1'b0;
    end else if (sysref_rise && !aligned_r) begin
      cnt_r <= CNT_W'(1);
      aligned_r <= 1'b1;
    end else if (cnt_r == period - CNT_W'(1)) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  // a later pulse must land on a period boundary, any multiple of E*32
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      mismatch_r <= 1'b0;
    end else begin
      mismatch_r <= i_enable & aligned_r & sysref_rise & (cnt_r != '0);
    end
  end

  assign o_mismatch = mismatch_r;

endmodule : rlei_sysref_check

// ---- src/rlei_rx_link_error_irq.sv ----
// receive link error status, interrupt enable and wishbone register slave
//
// Operation
// - link sink ready low with valid sets bit1
// - reference pulse period not E*32 multiple sets bit0
// - enable register at 0x64 gates each error
// - bit22 ecc fatal enable, resets one
// - bit21 ecc corrected enable, resets zero
// - bit20 elastic overflow enable, resets one
// - bits19,18 alignment unlock enables, reset one
// - bits17,16 gearbox over/under enables, reset one
// - bit14 crc enable resets one; reserved bits
// - bits11..8 parity, marker, header enables reset one
// - bits7..4 deskew, fifo, lock enables reset one
// - bits3..1 sink-not-ready enables reset zero
// - bit0 reference pulse mismatch enable resets one
// - frame sink ready low with valid sets bit2
module rlei_rx_link_error_irq #(
  parameter int EMB_LEN_W = rlei_pkg::EMB_LEN_W,
  parameter logic [rlei_pkg::EMB_LEN_W-1:0] EMB_LENGTH_DEFAULT = rlei_pkg::EMB_LENGTH_RESET
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire rlei_pkg::rlei_stream_t i_link_stream,
  input wire rlei_pkg::rlei_stream_t i_frame_stream,
  input wire rlei_pkg::rlei_stream_t i_cmd_stream,
  input wire rlei_pkg::rlei_fault_t i_fault,
  input wire logic i_sysref,
  output logic o_irq
);

  // E is held in a register of EMB_LEN_W bits, the package types assume it
  if (EMB_LEN_W != rlei_pkg::EMB_LEN_W) begin : g_bad_width
    $error("EMB_LEN_W must match the package width");
  end
  if (EMB_LENGTH_DEFAULT == '0) begin : g_bad_length
    $error("EMB_LENGTH_DEFAULT must be at least one");
  end

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [31:0] err_status_r;
  logic [31:0] err_status_nxt;
  logic [31:0] err_enable_r;
  logic sysref_alwayson_r;
  logic [EMB_LEN_W-1:0] emb_length_r;
  logic ack_r;
  logic [31:0] rd_dat_r;
  logic irq_r;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic [31:0] byte_mask;
  logic [31:0] rd_mux;

  // the access completes on the edge that raises ack
  assign bus_req = i_wb_cyc & i_wb_stb & ~ack_r;
  assign bus_wr = bus_req & i_wb_we;
  assign bus_rd = bus_req & ~i_wb_we;

  // expand byte selects into a bit mask, used by the status and enable registers
  function automatic logic [31:0] sel_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{sel[b]}};
    end
    return m;
  endfunction : sel_mask

  // address compare shared by read mux and write strobes
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr == ofs;
  endfunction : hit

  assign byte_mask = sel_mask(i_wb_sel);

  // ---------------------------------------------------------------
  // pin synchroniser for the reference pulse
  // ---------------------------------------------------------------
  logic sysref_meta_r;
  logic sysref_sync_r;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sysref_meta_r <= 1'b0;
      sysref_sync_r <= 1'b0;
    end else begin
      sysref_meta_r <= i_sysref;
      sysref_sync_r <= sysref_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // event sources
  // ---------------------------------------------------------------
  logic [2:0] ready_err;
  logic sysref_mismatch;
  rlei_pkg::rlei_stream_t streams [3];

  assign streams[0] = i_link_stream;
  assign streams[1] = i_frame_stream;
  assign streams[2] = i_cmd_stream;

  // one monitor per sink: link data, frame data, command
  // the sink is expected never to stall; tying ready high silences these
  for (genvar g = 0; g < 3; g++) begin : g_ready_mon
    rlei_ready_mon u_mon (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_stream(streams[g]),
      .o_err(ready_err[g])
    );
  end

  rlei_sysref_check #(
    .EMB_LEN_W(EMB_LEN_W)
  ) u_sysref_check (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_enable(sysref_alwayson_r),
    .i_emb_length(emb_length_r),
    .i_sysref_sync(sysref_sync_r),
    .o_mismatch(sysref_mismatch)
  );

  // gather all events into the status layout
  logic [31:0] err_event;

  always_comb begin
    err_event = '0;
    err_event[rlei_pkg::BIT_SYSREF_LEMC] = sysref_mismatch;
    err_event[rlei_pkg::BIT_LINK_READY] = ready_err[0];
    err_event[rlei_pkg::BIT_FRAME_READY] = ready_err[1];
    err_event[rlei_pkg::BIT_CMD_READY] = ready_err[2];
    err_event[rlei_pkg::BIT_CDR_LOCK] = i_fault.cdr_lock;
    err_event[rlei_pkg::BIT_PCFIFO_FULL] = i_fault.pcfifo_full;
    err_event[rlei_pkg::BIT_PCFIFO_EMPTY] = i_fault.pcfifo_empty;
    err_event[rlei_pkg::BIT_LANE_DESKEW] = i_fault.lane_deskew;
    err_event[rlei_pkg::BIT_INV_SYNC_HDR] = i_fault.inv_sync_hdr;
    err_event[rlei_pkg::BIT_INV_EOMB] = i_fault.inv_eomb;
    err_event[rlei_pkg::BIT_INV_EOEMB] = i_fault.inv_eoemb;
    err_event[rlei_pkg::BIT_CMD_PARITY] = i_fault.cmd_parity;
    err_event[rlei_pkg::BIT_CRC] = i_fault.crc;
    err_event[rlei_pkg::BIT_GEARBOX_UNDER] = i_fault.gearbox_under;
    err_event[rlei_pkg::BIT_GEARBOX_OVER] = i_fault.gearbox_over;
    err_event[rlei_pkg::BIT_HEADER_UNLOCK] = i_fault.header_unlock;
    err_event[rlei_pkg::BIT_EMB_UNLOCK] = i_fault.emb_unlock;
    err_event[rlei_pkg::BIT_ELASTIC_OVER] = i_fault.elastic_over;
    err_event[rlei_pkg::BIT_ECC_CORRECTED] = i_fault.ecc_corrected;
    err_event[rlei_pkg::BIT_ECC_FATAL] = i_fault.ecc_fatal;
  end

  // ---------------------------------------------------------------
  // sticky status: write-one-to-clear and clear-on-read
  // ---------------------------------------------------------------
  logic [31:0] status_clr;

  always_comb begin
    status_clr = '0;
    if (bus_wr && hit(i_wb_adr, rlei_pkg::OFS_ERR_STATUS)) begin
      status_clr = i_wb_dat & byte_mask;
    end else if (bus_rd && hit(i_wb_adr, rlei_pkg::OFS_ERR_STATUS)) begin
      status_clr = '1;
    end
  end

  // an event in the clearing cycle survives the clear
  assign err_status_nxt = ((err_status_r & ~status_clr) | err_event) & rlei_pkg::ERR_IMPL_MASK;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      err_status_r <= rlei_pkg::ERR_STATUS_RESET;
    end else begin
      err_status_r <= err_status_nxt;
    end
  end

  // ---------------------------------------------------------------
  // interrupt enable register
  // ---------------------------------------------------------------
  // reset image: bits 22,20..16,14,11..4,0 set; 21 and 3..1 clear
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      err_enable_r <= rlei_pkg::ERR_ENABLE_RESET;
    end else if (bus_wr && hit(i_wb_adr, rlei_pkg::OFS_ERR_ENABLE)) begin
      // reserved positions stay zero whatever is written
      err_enable_r <= ((err_enable_r & ~byte_mask) | (i_wb_dat & byte_mask))
        & rlei_pkg::ERR_IMPL_MASK;
    end
  end

  // ---------------------------------------------------------------
  // reference pulse control and extended multiblock length
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sysref_alwayson_r <= rlei_pkg::SYSREF_ALWAYSON_RESET;
    end else if (bus_wr && hit(i_wb_adr, rlei_pkg::OFS_SYSREF_ALWAYSON) && i_wb_sel[0]) begin
      sysref_alwayson_r <= i_wb_dat[0];
    end
  end

  // a zero length would make the period check meaningless, so it is ignored
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      emb_length_r <= EMB_LENGTH_DEFAULT;
    end else if (bus_wr && hit(i_wb_adr, rlei_pkg::OFS_EMB_LENGTH) && i_wb_sel[0]) begin
      if (i_wb_dat[EMB_LEN_W-1:0] != '0) begin
        emb_length_r <= i_wb_dat[EMB_LEN_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // read data and acknowledge
  // ---------------------------------------------------------------
  // unmapped addresses acknowledge with zero data
  always_comb begin
    rd_mux = '0;
    if (hit(i_wb_adr, rlei_pkg::OFS_ERR_STATUS)) begin
      rd_mux = err_status_r;
    end else if (hit(i_wb_adr, rlei_pkg::OFS_ERR_ENABLE)) begin
      rd_mux = err_enable_r;
    end else if (hit(i_wb_adr, rlei_pkg::OFS_SYSREF_ALWAYSON)) begin
      rd_mux = {31'h0000_0000, sysref_alwayson_r};
    end else if (hit(i_wb_adr, rlei_pkg::OFS_EMB_LENGTH)) begin
      rd_mux = 32'(emb_length_r);
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req;
    end
  end

  // status is captured before the clear-on-read takes it away
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rd_dat_r <= '0;
    end else if (bus_rd) begin
      rd_dat_r <= rd_mux;
    end
  end

  assign o_wb_ack = ack_r;
  assign o_wb_dat = rd_dat_r;

  // ---------------------------------------------------------------
  // interrupt output
  // ---------------------------------------------------------------
  // registered for a glitch-free pin; lags the status flag by one cycle
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(err_status_r & err_enable_r);
    end
  end

  assign o_irq = irq_r;

endmodule : rlei_rx_link_error_irq

// ---- verification/rlei_sink_model.sv ----
// downstream sink model answering the three receive streams
module rlei_sink_model (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [2:0] i_stall,
  output logic [2:0] o_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ready stays high, as a tie-high would, unless a test orders a stall
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_ready <= 3'h7;
    end else begin
      o_ready <= ~i_stall;
    end
  end
endmodule : rlei_sink_model

// ---- verification/rlei_rx_link_error_irq_assertions.sv ----
// port-level checks of the error interrupt block
module rlei_rx_link_error_irq_checker (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire rlei_pkg::rlei_stream_t i_link_stream,
  input wire rlei_pkg::rlei_fault_t i_fault,
  input wire logic o_irq
);
  logic [31:0] en_r;
  logic taken;
  assign taken = i_wb_cyc && i_wb_stb && !o_wb_ack;
  // shadow of the enable register so the interrupt checks know which flags count
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      en_r <= rlei_pkg::ERR_ENABLE_RESET;
    end else if (taken && i_wb_we && i_wb_adr == rlei_pkg::OFS_ERR_ENABLE) begin
      for (int b = 0; b < 4; b++) begin
        if (i_wb_sel[b]) begin
          en_r[8*b+:8] <= i_wb_dat[8*b+:8] & rlei_pkg::ERR_IMPL_MASK[8*b+:8];
        end
      end
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  a_ack_after_take: assert property (taken |=> o_wb_ack)
    else $error("ack missing after a taken request");
  a_ack_one_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
    else $error("ack without a request");
  a_enable_readback:
    assert property (o_wb_ack && !$past(i_wb_we) && $past(i_wb_adr) == rlei_pkg::OFS_ERR_ENABLE |-> o_wb_dat == en_r)
    else $error("enable register readback differs");
  a_reserved_read_zero:
    assert property (o_wb_ack && !$past(i_wb_we) && $past(i_wb_adr) inside {8'h60, 8'h64}
      |-> (o_wb_dat & ~rlei_pkg::ERR_IMPL_MASK) == 32'h0)
    else $error("reserved bits read nonzero");
  a_unmapped_read_zero:
    assert property (o_wb_ack && !$past(i_wb_we) && !($past(i_wb_adr) inside {8'h54, 8'h58, 8'h60, 8'h64})
      |-> o_wb_dat == 32'h0)
    else $error("unmapped read nonzero");
  a_link_raises_irq:
    assert property (i_link_stream.valid && !i_link_stream.ready && en_r[1] && !i_wb_cyc ##1 !i_wb_cyc [*3]
      |-> ##[0:1] o_irq)
    else $error("link sink stall gave no interrupt");
  a_fatal_raises_irq:
    assert property (i_fault.ecc_fatal && en_r[22] && !i_wb_cyc ##1 !i_wb_cyc [*2] |-> ##[0:1] o_irq)
    else $error("fatal fault gave no interrupt");
  a_irq_sticky_idle: assert property (!i_wb_cyc ##1 (o_irq && !i_wb_cyc) |=> o_irq)
    else $error("interrupt dropped without a clear");
  a_masked_quiet: assert property (en_r == 32'h0 |=> !o_irq)
    else $error("interrupt with all enables cleared");
endmodule : rlei_rx_link_error_irq_checker

bind rlei_rx_link_error_irq rlei_rx_link_error_irq_checker u_checker (.i_clk, .i_reset, .i_wb_cyc, .i_wb_stb,
  .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_link_stream, .i_fault, .o_irq);

// ---- verification/rlei_rx_link_error_irq_tb.sv ----
// self-checking bench for the receive link error interrupt block
module rlei_rx_link_error_irq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, sr = 1'b0, ack, irq;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [2:0] vld = 3'h0, stall = 3'h0, rdy;
  rlei_pkg::rlei_fault_t flt = '0;
  int mismatches = 0, total_checks = 0;
  int pos[16] = '{4, 5, 6, 7, 8, 9, 10, 11, 14, 16, 17, 18, 19, 20, 21, 22};
  always #10 clk = ~clk;
  rlei_rx_link_error_irq dut (.i_clk(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_link_stream({vld[0], rdy[0]}), .i_frame_stream({vld[1], rdy[1]}), .i_cmd_stream({vld[2], rdy[2]}),
    .i_fault(flt), .i_sysref(sr), .o_irq(irq));
  rlei_sink_model sink (.i_clk(clk), .i_reset(rst), .i_stall(stall), .o_ready(rdy));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one classic cycle; values are read before the edge's own updates land
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk("ack", 1'b1, ack);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    bus(a, 1'b0, 32'h0);
    chk(n, e, q);
  endtask : rd
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick
  task automatic pulse(input int gap);
    tick(gap - 1);
    sr <= 1'b1;
    @(posedge clk);
    sr <= 1'b0;
  endtask : pulse
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  initial begin
    tick(5000);
    mismatches++;
    close_out();
  end
  initial begin
    tick(6);
    rst <= 1'b0;
    rd(8'h64, 32'h005f_4ff1, "enable reset");
    rd(8'h60, 32'h0, "status reset");
    rd(8'h70, 32'h0, "unmapped");
    chk("irq idle", 1'b0, irq);
    bus(8'h64, 1'b1, 32'hffff_ffff);
    rd(8'h64, 32'h007f_4fff, "enable all");
    bus(8'h64, 1'b1, 32'h0);
    flt <= 16'h0001;
    @(posedge clk);
    flt <= '0;
    tick(5);
    chk("irq masked", 1'b0, irq);
    rd(8'h60, 32'h10, "masked flag");
    rd(8'h60, 32'h0, "read cleared");
    $display("test registers finished");
    bus(8'h64, 1'b1, 32'h007f_4fff);
    for (int k = 0; k < 16; k++) begin
      flt <= 16'h0001 << k;
      @(posedge clk);
      flt <= '0;
      tick(4);
      chk("irq fault", 1'b1, irq);
      rd(8'h60, 32'h1 << pos[k], "fault flag");
      tick(2);
      chk("irq cleared", 1'b0, irq);
    end
    flt <= 16'h0500;
    @(posedge clk);
    flt <= '0;
    bus(8'h60, 1'b1, 32'h4000);
    tick(2);
    chk("irq partial clear", 1'b1, irq);
    rd(8'h60, 32'h2_0000, "one left");
    $display("test faults finished");
    bus(8'h64, 1'b1, 32'he);
    vld <= 3'h7;
    tick(4);
    vld <= 3'h0;
    rd(8'h60, 32'h0, "ready kept");
    for (int s = 0; s < 3; s++) begin
      stall <= 3'h1 << s;
      tick(2);
      vld <= 3'h1 << s;
      @(posedge clk);
      vld <= 3'h0;
      stall <= 3'h0;
      tick(5);
      chk("irq stream", 1'b1, irq);
      rd(8'h60, 32'h2 << s, "stream flag");
    end
    $display("test streams finished");
    bus(8'h64, 1'b1, 32'h1);
    bus(8'h58, 1'b1, 32'h2);
    bus(8'h58, 1'b1, 32'h0);
    rd(8'h58, 32'h2, "length kept");
    rd(8'h54, 32'h0, "alwayson reset");
    pulse(2);
    pulse(50);
    tick(6);
    rd(8'h60, 32'h0, "check off");
    bus(8'h54, 1'b1, 32'h1);
    rd(8'h54, 32'h1, "alwayson set");
    pulse(2);
    pulse(64);
    pulse(128);
    tick(6);
    rd(8'h60, 32'h0, "period match");
    pulse(84);
    tick(8);
    chk("irq period", 1'b1, irq);
    rd(8'h60, 32'h1, "period flag");
    $display("test reference pulse finished");
    close_out();
  end
endmodule : rlei_rx_link_error_irq_tb
